// ---- smw_stop_ctrl.sv ----
// Purpose: Full-halt entry and release sequencer
// Assumes: Oscillator enables act outside; core clock stalls during halt
// Notes: Wake capture is clockless, the sequencer resumes on clock return
`timescale 1ns/1ps
`default_nettype none
module smw_stop_ctrl #(
  parameter int WARM_W = smw_pkg::SMW_WARM_W,
  parameter int MCYC = smw_pkg::SMW_MCYC_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Software control
  input wire logic halt_req_i,
  input wire logic release_mode_select_i,
  input wire logic [1:0] run_mode_i,
  input wire logic [WARM_W-1:0] warmup_count_value_i,
  input wire logic warmup_source_select_i,
  // Wake sources
  input wire logic wake_pin_i,
  input wire logic [7:0] key_i,
  input wire logic [7:0] key_en_i,
  input wire logic key_level_i,
  input wire logic vdet_low_i,
  input wire logic vdet_reset_en_i,
  // Oscillator and core control
  output logic high_osc_en_o,
  output logic low_osc_en_o,
  output logic warmup_src_high_o,
  output logic core_hold_o,
  output logic halt_active_o,
  output logic vdet_reset_o,
  output logic tg_clear_o,
  output logic resume_o,
  output logic [1:0] resume_mode_o,
  // Port view of the wake pin
  output logic shared_port_bit_o,
  output logic external_interrupt_five_o
);
  smw_pkg::smw_state_e state_q;
  smw_pkg::smw_state_e state_d;
  logic [1:0] entry_mode_q;
  logic [WARM_W-1:0] warm_q;
  logic [7:0] arm_cnt_q;
  logic armed_q;
  logic hosc_q;
  logic losc_q;
  logic src_q;
  logic hold_q;
  logic halt_q;
  logic vrst_q;
  logic clr_q;
  logic res_q;
  logic [1:0] rmode_q;
  logic pin_s;
  logic pin_q;
  logic vdet_s;
  logic key_hit;
  logic wake_async;
  logic wake_sync;
  logic level_block;
  logic warm_done;
  logic arm_done;
  logic vdet_rst;
  logic enter_arm;
  logic enter_warm;
  logic run_next;
  logic warm_next;
  logic osc_off;
  logic hosc_d;
  logic losc_d;
  logic src_d;
  logic hold_d;
  logic halt_d;
  logic vrst_d;
  logic clr_d;
  logic res_d;
  logic [7:0] arm_cnt_d;
  logic [WARM_W-1:0] warm_d;

  // Release level match for each enabled key; a key that is off never wakes
  function automatic logic [7:0] key_match(input logic [7:0] keys, input logic [7:0] en, input logic lvl);
    return en & ~(keys ^ {8{lvl}});
  endfunction

  // Oscillators that the entry run mode needs back on release
  function automatic logic needs_high_osc(input logic [1:0] mode);
    return (mode != smw_pkg::SMW_LOW_RUN);
  endfunction

  function automatic logic needs_low_osc(input logic [1:0] mode);
    return (mode != smw_pkg::SMW_SINGLE_FAST);
  endfunction

  // Port and interrupt view of the wake pin for pre-halt testing
  smw_sync3 u_pin_sync (
    .clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i(wake_pin_i),
    .q_o(pin_s)
  );
  smw_sync3 u_vdet_sync (
    .clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i(vdet_low_i),
    .q_o(vdet_s)
  );
  // Clockless capture so wake works with both oscillators stopped
  smw_wake_latch u_wake (
    .arm_i(armed_q),
    .level_mode_i(release_mode_select_i),
    .wake_pin_i(wake_pin_i),
    .key_hit_i(key_hit),
    .vdet_low_i(vdet_low_i & vdet_reset_en_i),
    .wake_o(wake_async)
  );
  smw_sync3 u_wake_sync (
    .clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .d_i(wake_async),
    .q_o(wake_sync)
  );

  assign key_hit = |key_match(key_i, key_en_i, key_level_i);
  assign level_block = release_mode_select_i & pin_s;
  assign warm_done = (warm_q == '0);
  // Arming waits one machine cycle so early edges and recoveries are ignored
  assign arm_done = (arm_cnt_q == 8'(MCYC - 1));
  assign vdet_rst = vdet_s & vdet_reset_en_i;
  assign enter_arm = (state_q == smw_pkg::SMW_RUN) && (state_d == smw_pkg::SMW_ARM);
  assign enter_warm = (state_q != smw_pkg::SMW_WARM) && (state_d == smw_pkg::SMW_WARM);
  assign run_next = (state_d == smw_pkg::SMW_RUN);
  assign warm_next = (state_d == smw_pkg::SMW_WARM);
  // Both oscillators stop for the halt and while the detector holds reset
  assign osc_off = (state_d == smw_pkg::SMW_HALT) || (state_d == smw_pkg::SMW_VRST);
  assign arm_cnt_d = (state_q == smw_pkg::SMW_ARM) ? arm_cnt_q + 8'h01 : 8'h00;
  assign warm_d = enter_warm ? warmup_count_value_i :
    ((state_q == smw_pkg::SMW_WARM) && !warm_done) ? warm_q - WARM_W'(1) : warm_q;
  // Warm-up clock follows the entry clock, not the select field
  assign src_d = warm_next ? needs_high_osc(entry_mode_q) : (run_next ? warmup_source_select_i : src_q);
  assign hosc_d = osc_off ? 1'b0 : (warm_next ? needs_high_osc(entry_mode_q) : hosc_q);
  assign losc_d = osc_off ? 1'b0 : (warm_next ? needs_low_osc(entry_mode_q) : losc_q);
  assign hold_d = !run_next;
  assign halt_d = (state_d == smw_pkg::SMW_HALT) || (state_d == smw_pkg::SMW_ARM);
  assign vrst_d = (state_d == smw_pkg::SMW_VRST);
  assign clr_d = (state_d == smw_pkg::SMW_RESUME);
  assign res_d = (state_d == smw_pkg::SMW_RESUME);

  always_comb begin
    state_d = state_q;
    case (state_q)
      smw_pkg::SMW_RUN: begin
        if (halt_req_i && !level_block) begin
          state_d = smw_pkg::SMW_ARM;
        end
      end
      smw_pkg::SMW_ARM: begin
        if (arm_done) begin
          state_d = smw_pkg::SMW_HALT;
        end
      end
      smw_pkg::SMW_HALT: begin
        if (vdet_rst) begin
          state_d = smw_pkg::SMW_VRST;
        end else if (wake_sync) begin
          state_d = smw_pkg::SMW_WARM;
        end
      end
      smw_pkg::SMW_VRST: begin
        if (!vdet_s) begin
          state_d = smw_pkg::SMW_WARM;
        end
      end
      smw_pkg::SMW_WARM: begin
        // No return to halt from here whatever the pin or keys do
        if (warm_done) begin
          state_d = smw_pkg::SMW_RESUME;
        end
      end
      smw_pkg::SMW_RESUME: begin
        state_d = smw_pkg::SMW_RUN;
      end
      default: begin
        state_d = smw_pkg::SMW_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= smw_pkg::SMW_WARM;
    end else begin
      state_q <= state_d;
    end
  end

  // Entry mode is caught as the request is taken; a detector reset forces single-clock
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      entry_mode_q <= smw_pkg::SMW_SINGLE_FAST;
    end else if (state_d == smw_pkg::SMW_VRST) begin
      entry_mode_q <= smw_pkg::SMW_SINGLE_FAST;
    end else if (enter_arm) begin
      entry_mode_q <= run_mode_i;
    end
  end

  // Latch armed only after one machine cycle, so early edges are lost on purpose
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arm_cnt_q <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      arm_cnt_q <= arm_cnt_d;
      armed_q <= (state_d == smw_pkg::SMW_HALT);
    end
  end

  // Interrupt view is one flop behind the port view
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_s;
    end
  end

  // Warm-up counter, loaded on wake and run down with core held
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_q <= smw_pkg::SMW_WARM_RST;
    end else begin
      warm_q <= warm_d;
    end
  end

  // Reset brings back the high oscillator only, as for single-clock run
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hosc_q <= 1'b1;
      losc_q <= 1'b0;
    end else begin
      hosc_q <= hosc_d;
      losc_q <= losc_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_q <= 1'b1;
    end else begin
      src_q <= src_d;
    end
  end

  // Core stays held from the request through the resume cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_q <= 1'b1;
      halt_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      halt_q <= halt_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vrst_q <= 1'b0;
    end else begin
      vrst_q <= vrst_d;
    end
  end

  // One-cycle pulses; the timing generator clears on the same edge as resume
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clr_q <= 1'b0;
      res_q <= 1'b0;
    end else begin
      clr_q <= clr_d;
      res_q <= res_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rmode_q <= smw_pkg::SMW_SINGLE_FAST;
    end else begin
      rmode_q <= entry_mode_q;
    end
  end

  assign high_osc_en_o = hosc_q;
  assign low_osc_en_o = losc_q;
  assign warmup_src_high_o = src_q;
  assign core_hold_o = hold_q;
  assign halt_active_o = halt_q;
  assign vdet_reset_o = vrst_q;
  assign tg_clear_o = clr_q;
  assign resume_o = res_q;
  assign resume_mode_o = rmode_q;
  assign shared_port_bit_o = pin_s;
  assign external_interrupt_five_o = pin_q;
endmodule
`default_nettype wire

// ---- smw_pkg.sv ----
// Purpose: Constants and types shared by the stop mode wake controller
// Assumes: Single 125 MHz core clock, asynchronous active-low reset
// Notes: No register bus; control and status are plain ports
package smw_pkg;
  typedef enum logic [1:0] {
    SMW_SINGLE_FAST = 2'h0,
    SMW_DUAL_FAST = 2'h1,
    SMW_LOW_RUN = 2'h2
  } smw_run_e;
  typedef enum logic [2:0] {
    SMW_RUN = 3'h0,
    SMW_ARM = 3'h1,
    SMW_HALT = 3'h2,
    SMW_VRST = 3'h3,
    SMW_WARM = 3'h4,
    SMW_RESUME = 3'h5
  } smw_state_e;
  localparam int SMW_CLK_MHZ = 125;
  localparam int SMW_MCYC_NS = 32;
  localparam int SMW_MCYC_CYC = (SMW_MCYC_NS * SMW_CLK_MHZ + 999) / 1000;
  localparam int SMW_WARM_W = 16;
  localparam logic [SMW_WARM_W-1:0] SMW_WARM_RST = 16'h0000;
endpackage

// ---- smw_sync3.sv ----
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module smw_sync3 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Data
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic q_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_q <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_q <= s3_q;
      end
    end
  end
  assign q_o = q_q;
endmodule
`default_nettype wire

// ---- smw_wake_latch.sv ----
// Purpose: Clockless wake capture for the halt period
// Assumes: arm_i is a clean flop output; low while running
// Notes: Edge mode uses the pin as a clock, so no core clock is needed
`timescale 1ns/1ps
`default_nettype none
module smw_wake_latch (
  // Control
  input wire logic arm_i,
  input wire logic level_mode_i,
  // Sources
  input wire logic wake_pin_i,
  input wire logic key_hit_i,
  input wire logic vdet_low_i,
  // Result
  output logic wake_o
);
  logic edge_q;
  // Pin edge sets the flag asynchronously; disarm clears it
  always_ff @(posedge wake_pin_i or negedge arm_i) begin
    if (!arm_i) begin
      edge_q <= 1'b0;
    end else begin
      edge_q <= 1'b1;
    end
  end
  assign wake_o = arm_i & ((level_mode_i ? wake_pin_i : edge_q) | key_hit_i | vdet_low_i);
endmodule
`default_nettype wire

// ---- smw_monitor.sv ----
// Purpose: Port checker for the stop mode wake controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Synchroniser latency is left loose; fixed relations only
`timescale 1ns/1ps
`default_nettype none
module smw_monitor (
  // Clock, reset and controls
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic halt_req_i,
  input wire logic release_mode_select_i,
  // Design outputs
  input wire logic high_osc_en_o,
  input wire logic low_osc_en_o,
  input wire logic warmup_src_high_o,
  input wire logic core_hold_o,
  input wire logic halt_active_o,
  input wire logic vdet_reset_o,
  input wire logic tg_clear_o,
  input wire logic resume_o,
  input wire logic [1:0] resume_mode_o,
  input wire logic shared_port_bit_o,
  input wire logic external_interrupt_five_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic run;
  assign run = !core_hold_o;
  property p_hold; halt_active_o || vdet_reset_o |-> core_hold_o; endproperty
  a_hold: assert property (p_hold) else $error("core not held in halt");
  property p_refuse; run && halt_req_i && release_mode_select_i && shared_port_bit_o
    && $past(shared_port_bit_o) |=> !halt_active_o; endproperty
  a_refuse: assert property (p_refuse) else $error("halt entered with pin high");
  property p_enter; run && halt_req_i && !release_mode_select_i |=> halt_active_o; endproperty
  a_enter: assert property (p_enter) else $error("edge mode halt not entered");
  property p_clear; resume_o |-> tg_clear_o; endproperty
  a_clear: assert property (p_clear) else $error("no divider clear at resume");
  property p_pulse; resume_o |=> !resume_o ##1 !resume_o; endproperty
  a_pulse: assert property (p_pulse) else $error("resume not one pulse");
  property p_osc; resume_o |-> high_osc_en_o == (resume_mode_o != 2'h2)
    && low_osc_en_o == (resume_mode_o != 2'h0); endproperty
  a_osc: assert property (p_osc) else $error("wrong oscillators restarted");
  property p_src; resume_o |-> warmup_src_high_o == (resume_mode_o != 2'h2); endproperty
  a_src: assert property (p_src) else $error("wrong warm-up source");
  property p_vrst; vdet_reset_o |-> !halt_active_o && !resume_o; endproperty
  a_vrst: assert property (p_vrst) else $error("reset overlaps halt");
  property p_port; external_interrupt_five_o == $past(shared_port_bit_o); endproperty
  a_port: assert property (p_port) else $error("interrupt view mismatch");
  c_resume: cover property (resume_o);
  c_vrst: cover property (vdet_reset_o);
  c_refuse: cover property (run && halt_req_i && release_mode_select_i && shared_port_bit_o);
endmodule
bind smw_stop_ctrl smw_monitor u_mon (.core_clk_i, .resetn_i, .halt_req_i, .release_mode_select_i,
  .high_osc_en_o, .low_osc_en_o, .warmup_src_high_o, .core_hold_o, .halt_active_o, .vdet_reset_o,
  .tg_clear_o, .resume_o, .resume_mode_o, .shared_port_bit_o, .external_interrupt_five_o);
`default_nettype wire

// ---- smw_wake_model.sv ----
// Purpose: Far side model: wake pin, keys and supply detector
// Assumes: Changes land just after a clock edge
// Notes: Levels are held until told otherwise, as real pins are
`timescale 1ns/1ps
`default_nettype none
module smw_wake_model (
  // Clock
  input wire logic core_clk_i,
  // Wake sources
  output logic wake_pin_o,
  output logic [7:0] key_o,
  output logic vdet_low_o
);
  initial begin
    wake_pin_o = 1'b0;
    key_o = 8'h00;
    vdet_low_o = 1'b0;
  end
  // Pin level or edge, key level, supply state; applied on a core clock edge
  task automatic put(input logic p, input logic [7:0] k, input logic v);
    @(posedge core_clk_i);
    wake_pin_o <= p;
    key_o <= k;
    vdet_low_o <= v;
  endtask
endmodule
`default_nettype wire

// ---- smw_stop_ctrl_tb.sv ----
// Purpose: Self-checking bench for the stop mode wake controller
// Assumes: Clock keeps running in the halt, standing in for the restart
// Notes: Warm-up count kept short to bound the run
`timescale 1ns/1ps
`default_nettype none
module smw_stop_ctrl_tb;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, lvl = 1'b0, src = 1'b0, ken = 1'b0, vren = 1'b0, klvl = 1'b1;
  logic [1:0] mode = 2'h0;
  logic hosc, losc, wsrc, hold, hact, vrst, tgc, res, pbit, external_interrupt_five, wpin, vlow;
  logic [1:0] rmode;
  logic [7:0] keys;
  int bad_count = 0, checks = 0, cyc = 0;
  always #4 clk = ~clk;
  smw_wake_model u_far (.core_clk_i(clk), .wake_pin_o(wpin), .key_o(keys), .vdet_low_o(vlow));
  smw_stop_ctrl dut (.core_clk_i(clk), .resetn_i(rst_n), .halt_req_i(req), .release_mode_select_i(lvl),
    .run_mode_i(mode), .warmup_count_value_i(16'h0008), .warmup_source_select_i(src),
    .wake_pin_i(wpin), .key_i(keys), .key_en_i({7'h00, ken}), .key_level_i(klvl), .vdet_low_i(vlow),
    .vdet_reset_en_i(vren), .high_osc_en_o(hosc), .low_osc_en_o(losc), .warmup_src_high_o(wsrc),
    .core_hold_o(hold), .halt_active_o(hact), .vdet_reset_o(vrst), .tg_clear_o(tgc), .resume_o(res),
    .resume_mode_o(rmode), .shared_port_bit_o(pbit), .external_interrupt_five_o(external_interrupt_five));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Software keeps interrupts masked across every halt it requests
  task automatic halt;
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Waits for the resume pulse, then for the core to run again
  task automatic resumed(input logic [1:0] m);
    int n;
    for (n = 0; n < 300 && res !== 1'b1; n++) @(posedge clk);
    chk({2'h0, rmode}, {2'h0, m});
    chk({res, tgc, hosc, losc}, {2'h3, m != 2'h2, m != 2'h0});
    chk({3'h0, wsrc}, {3'h0, m != 2'h2});
    for (n = 0; n < 300 && hold !== 1'b0; n++) @(posedge clk);
    chk({3'h0, hold}, 4'h0);
    chk({3'h0, wsrc}, {3'h0, src});
  endtask
  always @(posedge clk) if (++cyc > 20000) begin bad_count++; close_out; end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    resumed(2'h0);
    lvl <= 1'b1;
    u_far.put(1'b1, 8'h00, 1'b0);
    repeat (6) @(posedge clk);
    chk({2'h0, pbit, external_interrupt_five}, 4'h3);
    halt;
    chk({3'h0, hact}, 4'h0);
    u_far.put(1'b0, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    halt;
    chk({3'h0, hact}, 4'h1);
    repeat (10) @(posedge clk);
    u_far.put(1'b1, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    u_far.put(1'b0, 8'h00, 1'b0);
    resumed(2'h0);
    lvl <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      mode <= m[1:0];
      src <= (m != 0);
      u_far.put(1'b1, 8'h00, 1'b0);
      repeat (5) @(posedge clk);
      halt;
      chk({3'h0, hact}, 4'h1);
      repeat (10) @(posedge clk);
      u_far.put(1'b0, 8'h00, 1'b0);
      repeat (4) @(posedge clk);
      chk({3'h0, hact}, 4'h1);
      u_far.put(1'b1, 8'h00, 1'b0);
      resumed(m[1:0]);
    end
    mode <= 2'h1;
    ken <= 1'b1;
    u_far.put(1'b0, 8'h00, 1'b0);
    halt;
    repeat (10) @(posedge clk);
    u_far.put(1'b0, 8'h01, 1'b0);
    repeat (5) @(posedge clk);
    u_far.put(1'b0, 8'h00, 1'b0);
    resumed(2'h1);
    klvl <= 1'b0;
    u_far.put(1'b0, 8'h01, 1'b0);
    halt;
    repeat (10) @(posedge clk);
    chk({3'h0, hact}, 4'h1);
    u_far.put(1'b0, 8'h00, 1'b0);
    repeat (5) @(posedge clk);
    u_far.put(1'b0, 8'h01, 1'b0);
    resumed(2'h1);
    ken <= 1'b0;
    klvl <= 1'b1;
    vren <= 1'b1;
    halt;
    repeat (10) @(posedge clk);
    u_far.put(1'b0, 8'h00, 1'b1);
    repeat (8) @(posedge clk);
    chk({2'h0, vrst, hact}, 4'h2);
    u_far.put(1'b0, 8'h00, 1'b0);
    resumed(2'h0);
    mode <= 2'h2;
    halt;
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({3'h0, hact}, 4'h0);
    rst_n <= 1'b1;
    resumed(2'h0);
    close_out;
  end
endmodule
`default_nettype wire
